// ==== logic/adc_highpass_filter.sv ====
// record-path high-pass filter with ahb-lite control registers
//
// How it works
// - filter is in the path after reset; bypass bit 0 set to 1 removes it.
// - order bit 10: 0 gives first-order dc removal, 1 second-order voice filter.
// - first-order corner fixed near 3.6 Hz at 44.1 kHz, not software adjustable.
// - second-order corner comes from 3-bit code at bits 9:7, reset 000.
// - coefficients scale corner with rate; 119.5 to 601 Hz at 48 kHz.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module adc_highpass_filter (
   input wire logic CLK,
   input wire logic RST_N,
   // ahb-lite slave; hsize is accepted but only whole words are decoded
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // record stream in from decimation, rate code on the same clock
   input wire hpf_pkg::rate_e ADC_RATE,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire hpf_pkg::stereo_s IN_SAMPLE,
   // record stream out to the later enhancement stages
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output hpf_pkg::stereo_s OUT_SAMPLE
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      // software-visible registers
      logic [hpf_pkg::REG_W-1:0] ctrl_a;
      logic [hpf_pkg::REG_W-1:0] ctrl_b;
      // bus data phase
      logic wr_pend;
      logic [29:0] wr_idx;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      // sample stage and filter history
      logic in_ready;
      logic stg_valid;
      hpf_pkg::stereo_s stg;
      hpf_pkg::chan_s [1:0] ch;
      logic order_prev;
      logic [hpf_pkg::BAND_W-1:0] band_prev;
      // registered output slot
      logic out_valid;
      hpf_pkg::stereo_s out;
   } state_s;

   state_s q;
   state_s n;

   // ****************************************
   // arithmetic helpers
   // ****************************************
   // one first-order section: y = (x - x1) + y1 - alpha * y1
   function automatic hpf_pkg::acc_t hp_step(
      input hpf_pkg::acc_t y1,
      input hpf_pkg::sample_t x,
      input hpf_pkg::sample_t x1,
      input hpf_pkg::coef_t a
   );
      hpf_pkg::acc_t d;
      logic signed [hpf_pkg::ACC_W+hpf_pkg::COEF_W:0] p;
      d = hpf_pkg::acc_t'(x) - hpf_pkg::acc_t'(x1);
      p = y1 * $signed({1'b0, a});
      return (d <<< hpf_pkg::FRAC) + y1 - hpf_pkg::acc_t'(p >>> hpf_pkg::FRAC);
   endfunction : hp_step

   // the difference term can reach twice full scale, so clip on the way out
   function automatic hpf_pkg::sample_t sat(input hpf_pkg::acc_t y);
      hpf_pkg::acc_t v;
      v = y >>> hpf_pkg::FRAC;
      if (v > hpf_pkg::SAT_MAX) begin
         v = hpf_pkg::SAT_MAX;
      end else if (v < hpf_pkg::SAT_MIN) begin
         v = hpf_pkg::SAT_MIN;
      end
      return v[hpf_pkg::SAMPLE_W-1:0];
   endfunction : sat

   function automatic hpf_pkg::band_e band_of(input hpf_pkg::rate_e r);
      hpf_pkg::band_e b;
      unique case (r)
         hpf_pkg::RATE_8K, hpf_pkg::RATE_11K025, hpf_pkg::RATE_12K: begin
            b = hpf_pkg::BAND_8_12;
         end
         hpf_pkg::RATE_16K, hpf_pkg::RATE_22K05, hpf_pkg::RATE_24K: begin
            b = hpf_pkg::BAND_16_24;
         end
         hpf_pkg::RATE_88K2, hpf_pkg::RATE_96K: begin
            b = hpf_pkg::BAND_88_96;
         end
         default: begin
            b = hpf_pkg::BAND_32_48;
         end
      endcase
      return b;
   endfunction : band_of

   // band and code pick one table entry; first order ignores the code
   function automatic hpf_pkg::coef_t coef_of(
      input logic order2_i,
      input logic [hpf_pkg::BAND_W-1:0] band_i,
      input logic [hpf_pkg::CORNER_W-1:0] corner_i
   );
      hpf_pkg::coef_t sel;
      if (order2_i) begin
         sel = hpf_pkg::COEF_APP[band_i][corner_i];
      end else begin
         sel = hpf_pkg::COEF_HIFI[band_i];
      end
      return sel;
   endfunction : coef_of

   // unmapped words read as zero so software can probe safely
   function automatic logic [31:0] reg_read(
      input logic [29:0] idx,
      input logic [hpf_pkg::REG_W-1:0] a,
      input logic [hpf_pkg::REG_W-1:0] b
   );
      logic [31:0] v;
      v = '0;
      if (idx == hpf_pkg::IDX_CTRL_A) begin
         v = 32'(a);
      end else if (idx == hpf_pkg::IDX_CTRL_B) begin
         v = 32'(b);
      end
      return v;
   endfunction : reg_read

   // the rate band belongs to the hardware, so a write keeps it
   function automatic logic [hpf_pkg::REG_W-1:0] merge_b(
      input logic [hpf_pkg::REG_W-1:0] old_v,
      input logic [hpf_pkg::REG_W-1:0] new_v
   );
      return (new_v & hpf_pkg::CTRL_B_WMASK) | (old_v & ~hpf_pkg::CTRL_B_WMASK);
   endfunction : merge_b

   // ****************************************
   // configuration decode
   // ****************************************
   logic bypass;
   logic order2;
   logic [hpf_pkg::CORNER_W-1:0] corner;
   logic [hpf_pkg::BAND_W-1:0] band;
   hpf_pkg::coef_t coef;

   always_comb begin
      bypass = q.ctrl_a[hpf_pkg::BYPASS_BIT];
      order2 = q.ctrl_b[hpf_pkg::ORDER_BIT];
      corner = q.ctrl_b[hpf_pkg::CORNER_LSB +: hpf_pkg::CORNER_W];
      band = q.ctrl_b[hpf_pkg::BAND_LSB +: hpf_pkg::BAND_W];
      coef = coef_of(order2, band, corner);
   end

   // ****************************************
   // history clear
   // ****************************************
   // a new order or rate band under old history would ring (a corner code change keeps history); restarting from zero
   // trades that for a single step transient
   logic hist_clear;

   always_comb begin
      hist_clear = bypass;
      if (order2 != q.order_prev) begin
         hist_clear = 1'b1;
      end
      if (band != q.band_prev) begin
         hist_clear = 1'b1;
      end
   end

   // ****************************************
   // per-channel filter datapath
   // ****************************************
   hpf_pkg::chan_s [1:0] ch_n;
   hpf_pkg::sample_t [1:0] ch_y;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      hpf_pkg::acc_t s1;
      hpf_pkg::acc_t s2;
      hpf_pkg::sample_t o1;
      hpf_pkg::sample_t x;

      // each channel keeps its own history; only the coefficient is shared
      always_comb begin
         x = q.stg.ch[c];
         s1 = hp_step(q.ch[c].y1a, x, q.ch[c].x1a, coef);
         o1 = sat(s1);
         s2 = hp_step(q.ch[c].y1b, o1, q.ch[c].x1b, coef);
         ch_n[c].x1a = x;
         ch_n[c].y1a = s1;
         if (order2) begin
            ch_n[c].x1b = o1;
            ch_n[c].y1b = s2;
            ch_y[c] = sat(s2);
         end else begin
            ch_n[c].x1b = '0;
            ch_n[c].y1b = '0;
            ch_y[c] = o1;
         end
      end
   end

   // ****************************************
   // output fifo
   // ****************************************
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   hpf_pkg::stereo_s fifo_in_data;
   hpf_pkg::stereo_s fifo_out_data;
   logic [hpf_pkg::CNT_W-1:0] fifo_count;

   always_comb begin
      if (bypass) begin
         fifo_in_data = q.stg;
      end else begin
         fifo_in_data.ch = ch_y;
      end
   end

   assign fifo_pop = fifo_out_valid && (!q.out_valid || OUT_READY);

   sample_fifo #(
      .W($bits(hpf_pkg::stereo_s)),
      .DEPTH(hpf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst_n(RST_N),
      .in_valid(q.stg_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data),
      .count(fifo_count)
   );

   // ****************************************
   // bus address phase
   // ****************************************
   // byte lanes are not decoded: every NONSEQ access is taken as a whole word; SEQ beats are not taken
   logic addr_take;
   logic [29:0] a_idx;

   assign a_idx = HADDR[31:2];
   assign addr_take = HSEL && (HTRANS == hpf_pkg::HTRANS_NONSEQ) && HREADY;

   // ****************************************
   // next state
   // ****************************************
   logic take;
   logic advance;
   logic [hpf_pkg::CNT_W+1:0] room;

   always_comb begin
      n = q;

      // bus write lands in the data phase
      if (q.wr_pend && q.wr_idx == hpf_pkg::IDX_CTRL_A) begin
         n.ctrl_a = HWDATA[hpf_pkg::REG_W-1:0];
      end
      if (q.wr_pend && q.wr_idx == hpf_pkg::IDX_CTRL_B) begin
         n.ctrl_b = merge_b(q.ctrl_b, HWDATA[hpf_pkg::REG_W-1:0]);
      end
      n.ctrl_b[hpf_pkg::BAND_LSB +: hpf_pkg::BAND_W] = band_of(ADC_RATE);

      n.wr_pend = addr_take && HWRITE;
      n.wr_idx = a_idx;
      n.hreadyout = 1'b1;
      n.hresp = hpf_pkg::HRESP_OKAY;
      // read data from the next values so a read right behind a write sees it
      if (addr_take && !HWRITE) begin
         n.hrdata = reg_read(a_idx, n.ctrl_a, n.ctrl_b);
      end

      // sample stage, filter history advances once per sample
      take = IN_VALID && q.in_ready;
      advance = q.stg_valid && fifo_in_ready;
      if (advance) begin
         n.stg_valid = 1'b0;
         if (hist_clear) begin
            n.ch = '0;
         end else begin
            n.ch = ch_n;
         end
         n.order_prev = order2;
         n.band_prev = band;
      end
      if (take) begin
         n.stg_valid = 1'b1;
         n.stg = IN_SAMPLE;
      end

      // conservative credit: ignores pops, so a taken sample always finds room
      room = (hpf_pkg::CNT_W + 2)'(fifo_count) + (hpf_pkg::CNT_W + 2)'(n.stg_valid)
           + (hpf_pkg::CNT_W + 2)'(take) + 1'b1;
      n.in_ready = (room <= (hpf_pkg::CNT_W + 2)'(hpf_pkg::FIFO_DEPTH));

      // registered output slot
      if (fifo_pop) begin
         n.out_valid = 1'b1;
         n.out = fifo_out_data;
      end else if (OUT_READY) begin
         n.out_valid = 1'b0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '0;
         q.ctrl_a <= hpf_pkg::CTRL_A_RESET;
         q.ctrl_b <= hpf_pkg::CTRL_B_RESET;
         q.hreadyout <= 1'b1;
         q.band_prev <= hpf_pkg::BAND_32_48;
      end else begin
         q <= n;
      end
   end

   assign HRDATA = q.hrdata;
   assign HREADYOUT = q.hreadyout;
   assign HRESP = q.hresp;
   assign IN_READY = q.in_ready;
   assign OUT_VALID = q.out_valid;
   assign OUT_SAMPLE = q.out;

endmodule : adc_highpass_filter

// ==== logic/hpf_pkg.sv ====
// constants, types and coefficient tables shared by the record high-pass filter
package hpf_pkg;

   // ****************************************
   // widths and stream carriers
   // ****************************************
   localparam int SAMPLE_W = 24;
   localparam int ACC_W = 44;
   localparam int FRAC = 16;
   localparam int COEF_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int CNT_W = 3;

   typedef logic signed [SAMPLE_W-1:0] sample_t;
   typedef logic signed [ACC_W-1:0] acc_t;
   typedef logic [COEF_W-1:0] coef_t;

   // index 0 is left, 1 is right
   typedef struct packed {
      sample_t [1:0] ch;
   } stereo_s;

   typedef struct packed {
      sample_t x1a;
      acc_t y1a;
      sample_t x1b;
      acc_t y1b;
   } chan_s;

   localparam acc_t SAT_MAX = acc_t'(2 ** (SAMPLE_W - 1) - 1);
   localparam acc_t SAT_MIN = -acc_t'(2 ** (SAMPLE_W - 1));

   // ****************************************
   // register map
   // ****************************************
   localparam int REG_W = 16;
   localparam logic [29:0] IDX_CTRL_A = 30'h05;
   localparam logic [29:0] IDX_CTRL_B = 30'h06;
   localparam logic [REG_W-1:0] CTRL_A_RESET = 16'h0000;
   localparam logic [REG_W-1:0] CTRL_B_RESET = 16'h2000;
   localparam logic [REG_W-1:0] CTRL_B_WMASK = 16'hcfff;
   localparam int BYPASS_BIT = 0;
   localparam int ORDER_BIT = 10;
   localparam int CORNER_LSB = 7;
   localparam int CORNER_W = 3;
   localparam int BAND_LSB = 12;
   localparam int BAND_W = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // ****************************************
   // sample rates and rate bands
   // ****************************************
   typedef enum logic [3:0] {
      RATE_8K = 4'h0, RATE_11K025 = 4'h1, RATE_12K = 4'h2,
      RATE_16K = 4'h3, RATE_22K05 = 4'h4, RATE_24K = 4'h5,
      RATE_32K = 4'h6, RATE_44K1 = 4'h7, RATE_48K = 4'h8,
      RATE_88K2 = 4'h9, RATE_96K = 4'ha
   } rate_e;

   typedef enum logic [BAND_W-1:0] {
      BAND_8_12 = 2'h0, BAND_16_24 = 2'h1, BAND_32_48 = 2'h2, BAND_88_96 = 2'h3
   } band_e;

   // ****************************************
   // coefficients, alpha in q16, corner tracks fs
   // ****************************************
   // second order is two equal sections; alpha is pre-shrunk so the
   // cascade, not each section, sits 3 dB down at the corner
   localparam coef_t COEF_APP [4][8] = '{
      '{16'h0a65, 16'h0d07, 16'h10a7, 16'h14c0, 16'h19ec, 16'h212c, 16'h297f, 16'h33ce},
      '{16'h0532, 16'h0689, 16'h0859, 16'h0a6a, 16'h0cf6, 16'h109b, 16'h14c5, 16'h19ec},
      '{16'h0294, 16'h0347, 16'h042a, 16'h0530, 16'h0679, 16'h0856, 16'h0a5a, 16'h0cf6},
      '{16'h0152, 16'h01a2, 16'h0214, 16'h0295, 16'h0337, 16'h042b, 16'h0530, 16'h0678}
   };
   localparam coef_t COEF_HIFI [4] = '{16'h009a, 16'h004d, 16'h0022, 16'h0011};

endpackage : hpf_pkg

// ==== logic/sample_fifo.sv ====
// small flip-flop fifo carrying filtered or bypassed stereo samples
`timescale 1ns/1ps
module sample_fifo #(
   parameter int W = 48,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
   } state_s;

   state_s q;
   state_s n;
   logic push;
   logic pop;

   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rd];
   assign count = q.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      n = q;
      if (push) begin
         n.mem[q.wr] = in_data;
         n.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         n.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      n.cnt = q.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

endmodule : sample_fifo

// ==== tb/adc_highpass_filter_assertions.sv ====
// port-level assertion checker for the record high-pass filter
`timescale 1ns/1ps
module hpf_checker (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic IN_VALID,
   input wire logic IN_READY,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire hpf_pkg::stereo_s OUT_SAMPLE
);
   // ****************************************
   // stream bookkeeping and properties
   // ****************************************
   logic [3:0] pend_q;
   logic [3:0] pend_d;
   wire logic take = IN_VALID && IN_READY;
   wire logic give = OUT_VALID && OUT_READY;
   wire logic rd = HSEL && HTRANS == hpf_pkg::HTRANS_NONSEQ && !HWRITE && HREADY;
   // wraps on a spurious output so the bound below catches it
   always_comb pend_d = pend_q + 4'(take) - 4'(give);
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) pend_q <= 4'h0;
      else pend_q <= pend_d;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_resp_okay: assert property (HRESP == hpf_pkg::HRESP_OKAY) else $error("hresp not okay");
   a_zero_wait: assert property (HREADYOUT == 1'b1) else $error("hreadyout low");
   a_rdata_upper: assert property (HRDATA[31:16] == 16'h0000) else $error("read data upper half set");
   a_rdata_stands: assert property (!rd |=> $stable(HRDATA)) else $error("read data moved");
   a_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID) else $error("valid dropped");
   a_out_data_hold: assert property (OUT_VALID && !OUT_READY |=> $stable(OUT_SAMPLE)) else $error("sample moved");
   a_in_to_out: assert property (take |-> ##[1:3] OUT_VALID) else $error("no output after input");
   a_one_per_in: assert property (give |-> pend_q != 4'h0) else $error("output without input");
   a_pend_bound: assert property (pend_q <= 4'h7) else $error("too many samples held");
   c_both: cover property (take && give);
   c_refuse: cover property (IN_VALID && !IN_READY);
   c_read: cover property (rd);
endmodule : hpf_checker

bind adc_highpass_filter hpf_checker u_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
   .OUT_SAMPLE(OUT_SAMPLE));

// ==== tb/record_sink.sv ====
// downstream record-path model that accepts samples at full or stalling pace
`timescale 1ns/1ps
module record_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   output logic ready
);
   // ****************************************
   // ready pattern
   // ****************************************
   logic [7:0] lfsr_q;
   // slow pace accepts one cycle in eight so the fifo really fills
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_q <= 8'h5b;
         ready <= 1'b0;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         ready <= !slow || lfsr_q[2:0] == 3'h0;
      end
   end
endmodule : record_sink

// ==== tb/tb.sv ====
// self-checking bench for the record high-pass filter
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] A = {hpf_pkg::IDX_CTRL_A, 2'h0};
   localparam logic [31:0] B = {hpf_pkg::IDX_CTRL_B, 2'h0};
   localparam logic [31:0] CFG [4] = '{32'h0000, 32'h0400, 32'h0780, 32'h0680};
   logic CLK;
   logic RST_N;
   logic HSEL;
   logic [31:0] HADDR;
   logic [1:0] HTRANS;
   logic HWRITE;
   logic [31:0] HWDATA;
   logic [31:0] HRDATA;
   logic HREADYOUT;
   logic HRESP;
   hpf_pkg::rate_e ADC_RATE;
   logic IN_VALID;
   logic IN_READY;
   hpf_pkg::stereo_s IN_SAMPLE;
   logic OUT_VALID;
   logic OUT_READY;
   hpf_pkg::stereo_s OUT_SAMPLE;
   logic slow;
   int num_errors;
   int tests_run;
   int seed;
   logic [31:0] rd;
   hpf_pkg::stereo_s s;
   hpf_pkg::stereo_s got_q[$];
   hpf_pkg::stereo_s exp_q[$];
   logic signed [23:0] last_l [4];

   adc_highpass_filter dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ADC_RATE(ADC_RATE), .IN_VALID(IN_VALID),
      .IN_READY(IN_READY), .IN_SAMPLE(IN_SAMPLE), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
      .OUT_SAMPLE(OUT_SAMPLE));
   record_sink sink (.clk(CLK), .rst_n(RST_N), .slow(slow), .ready(OUT_READY));

   // ****************************************
   // helpers
   // ****************************************
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   always @(posedge CLK) if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) got_q.push_back(OUT_SAMPLE);

   function automatic logic [1:0] band_of(int r);
      if (r <= 2) return 2'h0;
      if (r <= 5) return 2'h1;
      if (r <= 8) return 2'h2;
      return 2'h3;
   endfunction : band_of

   task automatic finish_test();
      $display("mismatches %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic chk_reg(string name, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_reg

   task automatic chk_smp(string name, hpf_pkg::stereo_s exp, hpf_pkg::stereo_s got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_smp

   // a bus or stream wait that never ends is a failure, not a hang
   task automatic wait_hi(bit strm);
      int n;
      logic seen;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
         seen = (strm ? IN_READY : HREADYOUT) === 1'b1;
      end while (!seen && n < 200);
      if (!seen) begin
         num_errors++;
         finish_test();
      end
   endtask : wait_hi

   task automatic bus(logic wr, logic [31:0] addr, logic [31:0] wdata);
      HSEL <= 1'b1;
      HADDR <= addr;
      HTRANS <= hpf_pkg::HTRANS_NONSEQ;
      HWRITE <= wr;
      wait_hi(1'b0);
      HTRANS <= 2'h0;
      HWDATA <= wdata;
      wait_hi(1'b0);
      rd = HRDATA;
   endtask : bus

   task automatic send(hpf_pkg::stereo_s x);
      IN_VALID <= 1'b1;
      IN_SAMPLE <= x;
      wait_hi(1'b1);
   endtask : send

   task automatic drain(int n);
      IN_VALID <= 1'b0;
      for (int k = 0; k < 600 && got_q.size() < n; k++) @(posedge CLK);
      chk_reg("output count", 32'(n), 32'(got_q.size()));
   endtask : drain

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      seed = 32'hebe87a50;
      num_errors = 0;
      tests_run = 0;
      RST_N = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HWDATA = 32'h0;
      ADC_RATE = hpf_pkg::RATE_48K;
      IN_VALID = 1'b0;
      IN_SAMPLE = '0;
      slow = 1'b0;
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      bus(1'b0, A, 32'h0);
      chk_reg("ctrl_a reset", 32'h0000, rd);
      bus(1'b0, B, 32'h0);
      chk_reg("ctrl_b reset", 32'h2000, rd);
      bus(1'b1, B, 32'hffff_ffff);
      bus(1'b0, B, 32'h0);
      chk_reg("ctrl_b band kept", 32'hefff, rd);
      bus(1'b1, A, 32'hffff_a5a4);
      bus(1'b0, A, 32'h0);
      chk_reg("ctrl_a", 32'ha5a4, rd);
      bus(1'b1, 32'h1c, 32'h1234);
      bus(1'b0, 32'h1c, 32'h0);
      chk_reg("unmapped", 32'h0, rd);
      for (int r = 0; r < 11; r++) begin
         ADC_RATE <= hpf_pkg::rate_e'(r);
         repeat (2) @(posedge CLK);
         bus(1'b0, B, 32'h0);
         chk_reg("band", {30'h0, band_of(r)}, {30'h0, rd[13:12]});
      end
      ADC_RATE <= hpf_pkg::RATE_48K;
      // bypass under a stalling sink: exact pass-through, fifo refuses then drains
      bus(1'b1, A, 32'h1);
      slow <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         s = {24'($random(seed)), 24'($random(seed))};
         exp_q.push_back(s);
         send(s);
      end
      drain(12);
      foreach (got_q[i]) chk_smp("bypass", exp_q[i], got_q[i]);
      slow <= 1'b0;
      // dc step on left only: first order keeps most, wider corners remove more
      for (int c = 0; c < 4; c++) begin
         ADC_RATE <= c == 3 ? hpf_pkg::RATE_8K : hpf_pkg::RATE_48K;
         bus(1'b1, B, CFG[c]);
         got_q.delete();
         send('0);
         drain(1);
         bus(1'b1, A, 32'h0);
         got_q.delete();
         for (int i = 0; i < 16; i++) send({24'h0, 24'h100000});
         drain(16);
         chk_reg("step head", 32'h0010_0000, {8'h0, got_q[0].ch[0]});
         foreach (got_q[i]) chk_reg("right idle", 32'h0, {8'h0, got_q[i].ch[1]});
         last_l[c] = got_q[15].ch[0];
         chk_reg("dc drops", 32'h1, {31'h0, last_l[c] < 24'sh100000});
         bus(1'b1, A, 32'h1);
      end
      chk_reg("hifi keeps bass", 32'h1, {31'h0, last_l[0] > 24'sh080000});
      chk_reg("order two cuts more", 32'h1, {31'h0, last_l[1] < last_l[0]});
      chk_reg("corner code", 32'h1, {31'h0, last_l[2] < last_l[1]});
      finish_test();
   end
endmodule : tb
